//--- dop_defines.vh
// Register map, field positions, reset values and timing counts of the display output block.
`ifndef DOP_DEFINES_VH
`define DOP_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DOP_ADDR_W 16
`define DOP_OFS_TIMING_CFG 16'h8308
`define DOP_OFS_OUTPUT_CFG 16'h830c
`define DOP_OFS_STATUS 16'h8310

// ----------------------------------------------------------------
// Display timing configuration fields
// ----------------------------------------------------------------
`define DOP_BIT_PANEL_POWER_EN 0
`define DOP_BIT_CRT_VSYNC_EN 1
`define DOP_BIT_CRT_HSYNC_EN 2
`define DOP_BIT_BLANK_EN 3
`define DOP_TIMING_CFG_W 4
`define DOP_TIMING_CFG_RESET 4'h0

// ----------------------------------------------------------------
// Display output configuration fields
// ----------------------------------------------------------------
`define DOP_BIT_LB_TEST_MODE 15
`define DOP_BIT_LB_RW_SELECT 14
`define DOP_BIT_PANEL_DATA_HI_EN 13
`define DOP_BIT_PANEL_DATA_LO_EN 12
`define DOP_OUTPUT_CFG_W 16
`define DOP_OUTPUT_CFG_RESET 16'h0000

// ----------------------------------------------------------------
// Panel bus split and status fields
// ----------------------------------------------------------------
`define DOP_PANEL_W 18
`define DOP_PANEL_HI_LSB 9
`define DOP_STAGE_W 3
`define DOP_STAT_STAGE_LSB 0
`define DOP_STAT_DONE 4
`define DOP_STAT_BUSY 5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DOP_CLK_PERIOD_NS 40
`define DOP_STEP_TIME_NS 32000
`define DOP_STEP_CYCLES (`DOP_STEP_TIME_NS / `DOP_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define DOP_RESP_OKAY 2'b00
`define DOP_RESP_SLVERR 2'b10

`endif

//--- dop_panel_seq.v
// Flat-panel power sequencer stepping supply, clocks, bias and backlight in order.
`timescale 1ns/1ps
`default_nettype none
`include "dop_defines.vh"

module dop_panel_seq #(
  parameter integer STEP_CYCLES = `DOP_STEP_CYCLES
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Sequence requests
  input wire i_power_up,
  input wire i_power_down,
  // Sequence state
  output reg [`DOP_STAGE_W-1:0] o_stage,
  output wire o_done,
  output wire o_busy
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [3:0] S_OFF = 4'b0001;
  localparam [3:0] S_UP = 4'b0010;
  localparam [3:0] S_ON = 4'b0100;
  localparam [3:0] S_DOWN = 4'b1000;
  localparam [`DOP_STAGE_W-1:0] STAGE_MAX = 3'd4;
  localparam integer STEP_LAST_I = STEP_CYCLES - 1;
  localparam [15:0] STEP_LAST = STEP_LAST_I[15:0];

  reg [3:0] state;
  reg [15:0] wait_cnt;
  wire step_due;

  assign step_due = (wait_cnt == STEP_LAST);
  assign o_done = (state == S_ON);
  assign o_busy = (state == S_UP) || (state == S_DOWN);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // A reversal mid-sequence walks back from the stage already reached,
  // so a supply is never dropped while its dependants are still on.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= S_OFF;
      o_stage <= {`DOP_STAGE_W{1'b0}};
      wait_cnt <= 16'h0000;
    end else begin
      case (state)
        S_OFF: begin
          wait_cnt <= 16'h0000;
          if (i_power_up) begin
            state <= S_UP;
            o_stage <= 3'd1;
          end
        end
        S_UP: begin
          if (i_power_down) begin
            state <= S_DOWN;
            wait_cnt <= 16'h0000;
          end else if (step_due) begin
            wait_cnt <= 16'h0000;
            o_stage <= o_stage + 3'd1;
            if (o_stage + 3'd1 == STAGE_MAX) begin
              state <= S_ON;
            end
          end else begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        S_ON: begin
          wait_cnt <= 16'h0000;
          if (i_power_down) begin
            state <= S_DOWN;
            o_stage <= o_stage - 3'd1;
          end
        end
        S_DOWN: begin
          if (i_power_up) begin
            state <= S_UP;
            wait_cnt <= 16'h0000;
          end else if (step_due) begin
            wait_cnt <= 16'h0000;
            o_stage <= o_stage - 3'd1;
            if (o_stage == 3'd1) begin
              state <= S_OFF;
            end
          end else begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        default: begin
          state <= S_OFF;
          o_stage <= {`DOP_STAGE_W{1'b0}};
          wait_cnt <= 16'h0000;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- dop_output_ctrl.v
// Display output control: sync gating, panel power sequencing and output configuration.
`timescale 1ns/1ps
`default_nettype none
`include "dop_defines.vh"

// Behaviour
// - CRT vertical sync enable cleared holds CRT vertical sync output low.
// - CRT sync enable never touches panel sync; sequencer alone gates it.
// - Rising panel power enable starts power-up; a held level never restarts it.
// - Power-up order: supply, then clocks/syncs/pixel bus, then bias, then backlight.
// - Falling panel power enable powers down in reverse order.
// - Line buffer test mode bit opens the RAM to diagnostic access.
// - Rising test mode bit resets the line buffer write pointer.
// - Select bit: 0 uses write address, 1 uses read address.
// - Panel data high enable at 0 drives pixel lines 17 to 9 low.
// - Reset clears the configuration register; reserved bits 31:16 written zero.
module dop_output_ctrl #(
  parameter integer STEP_CYCLES = `DOP_STEP_CYCLES,
  parameter integer PANEL_W = `DOP_PANEL_W
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // AXI4-Lite write address
  input wire [`DOP_ADDR_W-1:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  // AXI4-Lite write data
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  // AXI4-Lite write response
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  // AXI4-Lite read address
  input wire [`DOP_ADDR_W-1:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  // AXI4-Lite read data
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  // Raw timing from the display timing generator
  input wire i_crt_hsync,
  input wire i_crt_vsync,
  input wire i_panel_hsync,
  input wire i_panel_vsync,
  input wire i_blank_n,
  input wire [PANEL_W-1:0] i_panel_data,
  // CRT outputs
  output reg o_crt_hsync,
  output reg o_crt_vsync,
  output reg o_blank_n,
  // Flat panel outputs
  output reg o_panel_vdd,
  output reg o_panel_clk_en,
  output reg o_panel_hsync,
  output reg o_panel_vsync,
  output reg [PANEL_W-1:0] o_panel_data,
  output reg o_panel_bias,
  output reg o_panel_backlight,
  // Compressed line buffer diagnostic controls
  output reg o_lb_test_mode,
  output reg o_lb_rw_select,
  output reg o_lb_wptr_reset
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer b;
    begin
      merge_bytes = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge_bytes[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  function is_mapped;
    input [`DOP_ADDR_W-1:0] addr;
    begin
      is_mapped = (addr == `DOP_OFS_TIMING_CFG) || (addr == `DOP_OFS_OUTPUT_CFG) ||
                  (addr == `DOP_OFS_STATUS);
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg [`DOP_TIMING_CFG_W-1:0] display_timing_configuration;
  reg [`DOP_OUTPUT_CFG_W-1:0] display_output_configuration;
  reg aw_held;
  reg [`DOP_ADDR_W-1:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg power_up_req;
  reg power_down_req;

  wire aw_take;
  wire w_take;
  wire have_aw;
  wire have_w;
  wire do_write;
  wire [`DOP_ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [31:0] next_timing_word;
  wire [31:0] next_output_word;
  wire [`DOP_TIMING_CFG_W-1:0] next_timing;
  wire [`DOP_OUTPUT_CFG_W-1:0] next_output;
  wire timing_hit;
  wire output_hit;
  wire ar_take;
  wire [`DOP_STAGE_W-1:0] seq_stage;
  wire seq_done;
  wire seq_busy;
  wire [31:0] status_word;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are taken in either order; the response waits
  // for both and no new write is taken while a response is pending.
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready = !w_held && !o_bvalid;
  assign aw_take = i_awvalid && o_awready;
  assign w_take = i_wvalid && o_wready;
  assign have_aw = aw_held || aw_take;
  assign have_w = w_held || w_take;
  assign do_write = have_aw && have_w && !o_bvalid;
  assign wr_addr = aw_held ? aw_addr : i_awaddr;
  assign wr_data = w_held ? w_data : i_wdata;
  assign wr_strb = w_held ? w_strb : i_wstrb;
  assign timing_hit = do_write && (wr_addr == `DOP_OFS_TIMING_CFG);
  assign output_hit = do_write && (wr_addr == `DOP_OFS_OUTPUT_CFG);

  assign next_timing_word = merge_bytes({28'h000_0000, display_timing_configuration},
                                        wr_data, wr_strb);
  assign next_output_word = merge_bytes({16'h0000, display_output_configuration},
                                        wr_data, wr_strb);
  assign next_timing = next_timing_word[`DOP_TIMING_CFG_W-1:0];
  // Upper bits are not stored, so anything written there is dropped.
  assign next_output = next_output_word[`DOP_OUTPUT_CFG_W-1:0];

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= {`DOP_ADDR_W{1'b0}};
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `DOP_RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= is_mapped(wr_addr) ? `DOP_RESP_OKAY : `DOP_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= i_awaddr;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= i_wdata;
          w_strb <= i_wstrb;
        end
        if (o_bvalid && i_bready) begin
          o_bvalid <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers and edge requests
  // ----------------------------------------------------------------
  // Edges are taken from the stored bit, not the bus, so rewriting the
  // same value never restarts a sequence or the write pointer.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      display_timing_configuration <= `DOP_TIMING_CFG_RESET;
      display_output_configuration <= `DOP_OUTPUT_CFG_RESET;
      power_up_req <= 1'b0;
      power_down_req <= 1'b0;
      o_lb_wptr_reset <= 1'b0;
    end else begin
      power_up_req <= timing_hit && next_timing[`DOP_BIT_PANEL_POWER_EN] &&
                      !display_timing_configuration[`DOP_BIT_PANEL_POWER_EN];
      power_down_req <= timing_hit && !next_timing[`DOP_BIT_PANEL_POWER_EN] &&
                        display_timing_configuration[`DOP_BIT_PANEL_POWER_EN];
      o_lb_wptr_reset <= output_hit && next_output[`DOP_BIT_LB_TEST_MODE] &&
                         !display_output_configuration[`DOP_BIT_LB_TEST_MODE];
      if (timing_hit) begin
        display_timing_configuration <= next_timing;
      end
      if (output_hit) begin
        display_output_configuration <= next_output;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign status_word = {26'h000_0000, seq_busy, seq_done, 1'b0, seq_stage};
  assign o_arready = !o_rvalid;
  assign ar_take = i_arvalid && o_arready;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `DOP_RESP_OKAY;
    end else if (ar_take) begin
      o_rvalid <= 1'b1;
      o_rresp <= `DOP_RESP_OKAY;
      case (i_araddr)
        `DOP_OFS_TIMING_CFG: o_rdata <= {28'h000_0000, display_timing_configuration};
        `DOP_OFS_OUTPUT_CFG: o_rdata <= {16'h0000, display_output_configuration};
        `DOP_OFS_STATUS: o_rdata <= status_word;
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= `DOP_RESP_SLVERR;
        end
      endcase
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Panel power sequencer
  // ----------------------------------------------------------------
  dop_panel_seq #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_seq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_power_up(power_up_req),
    .i_power_down(power_down_req),
    .o_stage(seq_stage),
    .o_done(seq_done),
    .o_busy(seq_busy)
  );

  // ----------------------------------------------------------------
  // Output gating
  // ----------------------------------------------------------------
  // All outputs set here are registered so the pins never glitch on a decode;
  // the price is one cycle of latency on sync and pixel data.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_crt_hsync <= 1'b0;
      o_crt_vsync <= 1'b0;
      o_blank_n <= 1'b0;
      o_panel_vdd <= 1'b0;
      o_panel_clk_en <= 1'b0;
      o_panel_hsync <= 1'b0;
      o_panel_vsync <= 1'b0;
      o_panel_data <= {PANEL_W{1'b0}};
      o_panel_bias <= 1'b0;
      o_panel_backlight <= 1'b0;
      o_lb_test_mode <= 1'b0;
      o_lb_rw_select <= 1'b0;
    end else begin
      o_crt_vsync <= display_timing_configuration[`DOP_BIT_CRT_VSYNC_EN] &&
                     i_crt_vsync;
      o_crt_hsync <= display_timing_configuration[`DOP_BIT_CRT_HSYNC_EN] && i_crt_hsync;
      o_blank_n <= display_timing_configuration[`DOP_BIT_BLANK_EN] && i_blank_n;
      o_panel_vdd <= (seq_stage >= 3'd1);
      o_panel_clk_en <= (seq_stage >= 3'd2);
      o_panel_hsync <= (seq_stage >= 3'd2) && i_panel_hsync;
      o_panel_vsync <= (seq_stage >= 3'd2) && i_panel_vsync;
      o_panel_bias <= (seq_stage >= 3'd3);
      o_panel_backlight <= (seq_stage >= 3'd4);
      if (seq_stage >= 3'd2) begin
        o_panel_data[PANEL_W-1:`DOP_PANEL_HI_LSB] <=
          display_output_configuration[`DOP_BIT_PANEL_DATA_HI_EN] ?
          i_panel_data[PANEL_W-1:`DOP_PANEL_HI_LSB] :
          {(PANEL_W-`DOP_PANEL_HI_LSB){1'b0}};
        o_panel_data[`DOP_PANEL_HI_LSB-1:0] <=
          display_output_configuration[`DOP_BIT_PANEL_DATA_LO_EN] ?
          i_panel_data[`DOP_PANEL_HI_LSB-1:0] : {`DOP_PANEL_HI_LSB{1'b0}};
      end else begin
        o_panel_data <= {PANEL_W{1'b0}};
      end
      o_lb_test_mode <= display_output_configuration[`DOP_BIT_LB_TEST_MODE];
      o_lb_rw_select <= display_output_configuration[`DOP_BIT_LB_RW_SELECT];
    end
  end

endmodule
`default_nettype wire

//--- dop_output_ctrl_sva.sv
// Checker for the display output block ports.
`timescale 1ns/1ps
`default_nettype none
module dop_output_ctrl_chk #(
  parameter integer STEP_CYCLES = 4,
  parameter integer PANEL_W = 18
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Raw timing
  input wire i_crt_vsync,
  input wire i_panel_vsync,
  input wire [PANEL_W-1:0] i_panel_data,
  // Outputs watched
  input wire o_crt_vsync,
  input wire o_panel_vdd,
  input wire o_panel_clk_en,
  input wire o_panel_vsync,
  input wire [PANEL_W-1:0] o_panel_data,
  input wire o_panel_bias,
  input wire o_panel_backlight,
  input wire o_lb_test_mode,
  input wire o_lb_wptr_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_crt_vs; o_crt_vsync |-> $past(i_crt_vsync); endproperty
  a_crt_vs: assert property (p_crt_vs) else $error("crt vsync without raw sync");
  property p_pnl_vs; o_panel_vsync |-> o_panel_clk_en && $past(i_panel_vsync); endproperty
  a_pnl_vs: assert property (p_pnl_vs) else $error("panel vsync outside sequence");
  property p_up_clk; $rose(o_panel_clk_en) |-> o_panel_vdd && $past(o_panel_vdd, STEP_CYCLES);
  endproperty
  a_up_clk: assert property (p_up_clk) else $error("clocks before supply settled");
  property p_up_bias; $rose(o_panel_bias) |-> o_panel_clk_en && $past(o_panel_clk_en, STEP_CYCLES);
  endproperty
  a_up_bias: assert property (p_up_bias) else $error("bias before clocks settled");
  property p_up_bl; $rose(o_panel_backlight) |-> o_panel_bias && $past(o_panel_bias, STEP_CYCLES);
  endproperty
  a_up_bl: assert property (p_up_bl) else $error("backlight before bias settled");
  property p_dn_bias; $fell(o_panel_bias) |-> !o_panel_backlight && !$past(o_panel_backlight, STEP_CYCLES);
  endproperty
  a_dn_bias: assert property (p_dn_bias) else $error("bias dropped before backlight");
  property p_dn_vdd; $fell(o_panel_vdd) |-> !o_panel_clk_en && !$past(o_panel_clk_en, STEP_CYCLES);
  endproperty
  a_dn_vdd: assert property (p_dn_vdd) else $error("supply dropped before clocks");
  property p_data; (o_panel_data != 0) |-> o_panel_clk_en && ((o_panel_data & ~$past(i_panel_data)) == 0);
  endproperty
  a_data: assert property (p_data) else $error("pixel bus not gated");
  property p_wptr_pulse; o_lb_wptr_reset |=> !o_lb_wptr_reset; endproperty
  a_wptr_pulse: assert property (p_wptr_pulse) else $error("pointer reset not a pulse");
  property p_wptr_cause; o_lb_wptr_reset |-> ##[0:1] o_lb_test_mode; endproperty
  a_wptr_cause: assert property (p_wptr_cause) else $error("pointer reset without test mode");
endmodule
bind dop_output_ctrl dop_output_ctrl_chk #(.STEP_CYCLES(STEP_CYCLES), .PANEL_W(PANEL_W)) chk_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_crt_vsync(i_crt_vsync), .i_panel_vsync(i_panel_vsync),
  .i_panel_data(i_panel_data), .o_crt_vsync(o_crt_vsync), .o_panel_vdd(o_panel_vdd),
  .o_panel_clk_en(o_panel_clk_en), .o_panel_vsync(o_panel_vsync), .o_panel_data(o_panel_data),
  .o_panel_bias(o_panel_bias), .o_panel_backlight(o_panel_backlight),
  .o_lb_test_mode(o_lb_test_mode), .o_lb_wptr_reset(o_lb_wptr_reset));
`default_nettype wire

//--- dop_panel_model.sv
// Flat panel model that flags any power step taken out of order.
`timescale 1ns/1ps
`default_nettype none
module dop_panel_model (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Panel pins
  input wire i_vdd,
  input wire i_clk_en,
  input wire i_bias,
  input wire i_backlight,
  input wire i_vsync,
  input wire [17:0] i_data,
  // Fault flag, sticky until reset
  output logic o_fault
);
  // A real panel can latch up when biased without clocks, so any overlap is a fault.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_fault <= 1'b0;
    end else if ((i_clk_en && !i_vdd) || (i_bias && !i_clk_en) || (i_backlight && !i_bias)) begin
      o_fault <= 1'b1;
    end else if (!i_clk_en && (i_vsync || (i_data != 18'h0_0000))) begin
      o_fault <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- dop_output_ctrl_tb_top.sv
// Self-checking testbench of the display output block.
`timescale 1ns/1ps
`default_nettype none
`include "dop_defines.vh"
module dop_output_ctrl_tb_top;
  localparam integer STEP = 4;
  logic i_clk = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
  logic i_rready = 0, i_crt_hsync = 0, i_crt_vsync = 0, i_panel_hsync = 0, i_panel_vsync = 0;
  logic i_blank_n = 0, hold = 0;
  logic [15:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, rd_d;
  logic [3:0] i_wstrb = 4'hf;
  logic [17:0] i_panel_data = 0, o_panel_data;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_crt_hsync, o_crt_vsync, o_blank_n;
  wire o_panel_vdd, o_panel_clk_en, o_panel_hsync, o_panel_vsync, o_panel_bias;
  wire o_panel_backlight, o_lb_test_mode, o_lb_rw_select, o_lb_wptr_reset, fault;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  int fails = 0, num_checks = 0, pulses = 0, n;
  dop_output_ctrl #(.STEP_CYCLES(STEP)) dut_u (.i_clk, .i_rst_n, .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_crt_hsync,
    .i_crt_vsync, .i_panel_hsync, .i_panel_vsync, .i_blank_n, .i_panel_data, .o_crt_hsync,
    .o_crt_vsync, .o_blank_n, .o_panel_vdd, .o_panel_clk_en, .o_panel_hsync, .o_panel_vsync,
    .o_panel_data, .o_panel_bias, .o_panel_backlight, .o_lb_test_mode, .o_lb_rw_select,
    .o_lb_wptr_reset);
  dop_panel_model pnl_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_vdd(o_panel_vdd),
    .i_clk_en(o_panel_clk_en), .i_bias(o_panel_bias), .i_backlight(o_panel_backlight),
    .i_vsync(o_panel_vsync), .i_data(o_panel_data), .o_fault(fault));
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_lb_wptr_reset) pulses <= pulses + 1;
    if (!hold) begin
      {i_crt_hsync, i_crt_vsync, i_panel_hsync, i_panel_vsync, i_blank_n} <= 5'($urandom);
      i_panel_data <= 18'($urandom);
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge i_clk);
    i_awaddr <= a; i_wdata <= d; i_awvalid <= 1; i_wvalid <= 1; i_bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(negedge i_clk);
      ta = i_awvalid && o_awready; tw = i_wvalid && o_wready; tb = o_bvalid; r = o_bresp;
      @(posedge i_clk);
      if (ta) i_awvalid <= 0;
      if (tw) i_wvalid <= 0;
      if (tb) break;
    end
    i_bready <= 0;
    if (n == 50) begin fails++; test_done(); end
    chk(r, er);
  endtask
  task automatic rd(input logic [15:0] a, input logic [1:0] er);
    logic ta, tr;
    logic [1:0] r;
    @(posedge i_clk);
    i_araddr <= a; i_arvalid <= 1; i_rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(negedge i_clk);
      ta = i_arvalid && o_arready; tr = o_rvalid; r = o_rresp; rd_d = o_rdata;
      @(posedge i_clk);
      if (ta) i_arvalid <= 0;
      if (tr) break;
    end
    i_rready <= 0;
    if (n == 50) begin fails++; test_done(); end
    chk(r, er);
  endtask
  // Counts negedges until the chosen output reaches the level; a bound cuts a hang short.
  task automatic wait_lvl(input int sel, input logic lv, output int c);
    logic s;
    for (c = 0; c < 200; c++) begin
      @(negedge i_clk);
      s = (sel == 0) ? o_panel_vdd : o_panel_backlight;
      if (s === lv) break;
    end
    if (c == 200) begin fails++; test_done(); end
  endtask
  function automatic logic [17:0] gate(input logic [31:0] cfg, input logic [17:0] raw);
    gate = raw & {{9{cfg[13]}}, {9{cfg[12]}}};
  endfunction
  int c0, c1, cnt, expp, e;
  logic [31:0] d, prev;
  logic [2:0] hs;
  logic [31:0] tbl[3] = '{32'h0000_1000, 32'h0000_3000, 32'h0000_2000};
  initial begin
    void'($urandom(29));
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1;
    // ----------------------------------------------------------------
    // Reset values and unmapped places
    // ----------------------------------------------------------------
    rd(`DOP_OFS_OUTPUT_CFG, `DOP_RESP_OKAY); chk(rd_d, 32'h0000_0000);
    rd(`DOP_OFS_TIMING_CFG, `DOP_RESP_OKAY); chk(rd_d, 32'h0000_0000);
    rd(16'h8400, `DOP_RESP_SLVERR); chk(rd_d, 32'h0000_0000);
    wr(16'h8400, 32'h0000_0001, `DOP_RESP_SLVERR);
    $display("test reset done");
    // ----------------------------------------------------------------
    // Output configuration, test mode and pointer reset
    // ----------------------------------------------------------------
    prev = 0; expp = 0;
    for (int i = 0; i < 8; i++) begin
      d = ((i < 2) ? 32'h0000_8000 : (i == 2) ? 32'h0000_0000 : $urandom) & 32'h0000_ffff;
      wr(`DOP_OFS_OUTPUT_CFG, d, `DOP_RESP_OKAY);
      rd(`DOP_OFS_OUTPUT_CFG, `DOP_RESP_OKAY); chk(rd_d, d & 32'h0000_ffff);
      if (d[15] && !prev[15]) expp++;
      chk(o_lb_test_mode, d[15]);
      chk(o_lb_rw_select, d[14]);
      chk(pulses, expp);
      prev = d;
    end
    $display("test config done");
    // ----------------------------------------------------------------
    // Reset in mid-run
    // ----------------------------------------------------------------
    i_rst_n <= 0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1;
    rd(`DOP_OFS_OUTPUT_CFG, `DOP_RESP_OKAY); chk(rd_d, 32'h0000_0000);
    chk(o_lb_test_mode, 0);
    $display("test midreset done");
    // ----------------------------------------------------------------
    // Power-up, sync gating, no restart, pixel gating, power-down
    // ----------------------------------------------------------------
    wr(`DOP_OFS_TIMING_CFG, 32'h0000_000d, `DOP_RESP_OKAY);
    wait_lvl(0, 1, c0); wait_lvl(1, 1, c1);
    chk(c1 + 1, 3 * STEP);
    rd(`DOP_OFS_STATUS, `DOP_RESP_OKAY); chk(rd_d & 32'h0000_0017, 32'h0000_0014);
    wr(`DOP_OFS_TIMING_CFG, 32'h0000_000d, `DOP_RESP_OKAY);
    cnt = 0; c0 = 0; c1 = 0; e = 0;
    repeat (40) begin
      hs = {i_crt_hsync, i_blank_n, i_panel_hsync};
      @(negedge i_clk);
      cnt += (o_panel_backlight !== 1'b1);
      c0 += (o_crt_vsync !== 1'b0);
      c1 += (o_panel_vsync === 1'b1);
      e += ({o_crt_hsync, o_blank_n, o_panel_hsync} !== hs);
    end
    chk(cnt, 0);
    chk(e, 0);
    chk(c0, 0);
    chk(c1 > 0, 1);
    hold = 1;
    foreach (tbl[i]) begin
      wr(`DOP_OFS_OUTPUT_CFG, tbl[i], `DOP_RESP_OKAY);
      repeat (2) @(negedge i_clk);
      chk(o_panel_data, gate(tbl[i], i_panel_data));
    end
    hold = 0;
    wr(`DOP_OFS_TIMING_CFG, 32'h0000_0000, `DOP_RESP_OKAY);
    wait_lvl(1, 0, c1); wait_lvl(0, 0, c0);
    chk(c0 + 1, 3 * STEP);
    chk(fault, 0);
    $display("test power done");
    // ----------------------------------------------------------------
    // Reversal in mid-sequence
    // ----------------------------------------------------------------
    wr(`DOP_OFS_TIMING_CFG, 32'h0000_0001, `DOP_RESP_OKAY);
    repeat (STEP + 3) @(posedge i_clk);
    wr(`DOP_OFS_TIMING_CFG, 32'h0000_0000, `DOP_RESP_OKAY);
    wait_lvl(0, 0, c0);
    chk(o_panel_backlight, 0);
    chk(fault, 0);
    $display("test reversal done");
    test_done();
  end
endmodule
`default_nettype wire
